/* rtl/sssm_defines.svh */
// Constants for the supply supervisor low-power mode block.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SSSM_DEFINES_SVH
`define SSSM_DEFINES_SVH

// =============================================
// Timing
`define SSSM_CLK_PERIOD_PS      5000
`define SSSM_FAST_DLY_NS        2000
`define SSSM_SLOW_DLY_NS        150000
`define SSSM_WAKE_GUARD_NS      1000
`define SSSM_FAST_DLY_CYC       ((`SSSM_FAST_DLY_NS * 1000) / `SSSM_CLK_PERIOD_PS)
`define SSSM_SLOW_DLY_CYC       ((`SSSM_SLOW_DLY_NS * 1000) / `SSSM_CLK_PERIOD_PS)
`define SSSM_WAKE_GUARD_CYC     ((`SSSM_WAKE_GUARD_NS * 1000) / `SSSM_CLK_PERIOD_PS)
`define SSSM_CNT_W              16
`define SSSM_CNT_ZERO           16'h0000

// =============================================
// Unit state codes (off, normal, full performance)
`define SSSM_ST_W               2
`define SSSM_ST_OFF             2'h0
`define SSSM_ST_NORM            2'h1
`define SSSM_ST_FULL            2'h2

`endif

/* rtl/sssm_pkg.sv */
// Types for the supply supervisor low-power mode block.
// Assumes nothing of its surroundings.
package sssm_pkg;
  // =============================================
  // Power mode of the core
  typedef enum logic [1:0] {
    SSSM_ACTIVE,
    SSSM_SLEEP,
    SSSM_WAKING
  } sssm_pwr_t;

  // =============================================
  // Configuration of one supervisor or monitor
  typedef struct packed {
    logic enable;
    logic lpmKeep;
    logic fullPerf;
  } sssm_unit_cfg_t;
endpackage

/* rtl/sssm_unit_if.sv */
// Interface carrying one unit's configuration and resolved state.
// Assumes the package has been compiled first.
`timescale 1ns/100ps
interface sssm_unit_if;
  sssm_pkg::sssm_unit_cfg_t cfg;      // Unit configuration
  logic                     autoCtl;  // Automatic control for the side
  logic                     deepLpm;  // Core in sleep level two to four
  logic [1:0]               state;    // Resolved unit state
  modport ctl  (output cfg, output autoCtl, output deepLpm, input state);
  modport unit (input cfg, input autoCtl, input deepLpm, output state);
endinterface

/* rtl/sssm_unit_mode.sv */
// Resolves the operating state of one supervisor or monitor.
// Assumes the controller drives the configuration through the interface.
`timescale 1ns/100ps
`include "sssm_defines.svh"
module sssm_unit_mode (
  // Unit side of the carrier
  sssm_unit_if.unit u
);
  // =============================================
  // Mode table
  // Enable low keeps the unit off everywhere
  always_comb begin
    if (!u.cfg.enable) begin
      u.state = `SSSM_ST_OFF;
    end else if (!u.deepLpm) begin
      u.state = u.cfg.fullPerf ? `SSSM_ST_FULL : `SSSM_ST_NORM;
    end else if (!u.cfg.lpmKeep) begin
      u.state = `SSSM_ST_OFF;
    end else if (!u.autoCtl) begin
      u.state = u.cfg.fullPerf ? `SSSM_ST_FULL : `SSSM_ST_NORM;
    end else begin
      // Automatic: normal only from full performance
      u.state = u.cfg.fullPerf ? `SSSM_ST_NORM : `SSSM_ST_OFF;
    end
  end
endmodule

/* rtl/sssm_top.sv */
// Supply supervisor mode selection and low-power entry control.
// Assumes synchronous inputs on clk_sys at 200 MHz; software drives config pins.
// Operation
// - Fast wake when low supervisor and monitor off or full
// - Full-performance clear selects slow 150 us wake
// - Interrupt within 1 us of entry wakes
// - Sleep entry by request or interrupt return
// - External, power or soft reset clears hang
// - High automatic control turns normal monitor off asleep
// - Overvoltage enable makes monitor raise reset
// - Hazard flagged for fast wake plus high off
// - Full-performance settling delay lasts 2 us
// - Normal settling delay lasts 150 us
`timescale 1ns/100ps
`include "sssm_defines.svh"
module sssm_top (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    softReset,
  // Low side control
  input  wire sssm_pkg::sssm_unit_cfg_t lowSupervisorCfg,
  input  wire sssm_pkg::sssm_unit_cfg_t lowMonitorCfg,
  input  wire logic                    lowSideAutoControl,
  input  wire logic                    lowSideWrite,
  // High side control
  input  wire sssm_pkg::sssm_unit_cfg_t highSupervisorCfg,
  input  wire sssm_pkg::sssm_unit_cfg_t highMonitorCfg,
  input  wire logic                    highSideAutoControl,
  input  wire logic                    highSideWrite,
  input  wire logic                    overvoltageProtectEnable,
  input  wire logic                    overvoltageDetect,
  // Core sleep control
  input  wire logic                    sleepRequest,
  input  wire logic                    isrReturnSleep,
  input  wire logic                    wakeInterrupt,
  // Status
  output logic                         lowSideSettlingFlag,
  output logic                         highSideSettlingFlag,
  output logic                         fastWakeMode,
  output logic                         hangHazard,
  output logic                         deepSleep,
  output logic                         wakeDone,
  output logic [`SSSM_ST_W-1:0]        lowSupervisorState,
  output logic [`SSSM_ST_W-1:0]        lowMonitorState,
  output logic [`SSSM_ST_W-1:0]        highSupervisorState,
  output logic [`SSSM_ST_W-1:0]        highMonitorState,
  output logic                         powerOnResetReq
);
  // =============================================
  // Helpers
  // Settling length for a side: 2 us when any enabled unit is full, else 150 us
  function automatic logic [`SSSM_CNT_W-1:0] settleLen(input logic full);
    settleLen = full ? `SSSM_CNT_W'(`SSSM_FAST_DLY_CYC)
                     : `SSSM_CNT_W'(`SSSM_SLOW_DLY_CYC);
  endfunction

  // =============================================
  // Unit mode resolution
  sssm_unit_if lowSupIf ();   // Low side supervisor
  sssm_unit_if lowMonIf ();   // Low side monitor
  sssm_unit_if highSupIf ();  // High side supervisor
  sssm_unit_if highMonIf ();  // High side monitor
  logic inDeep;               // Core in deep sleep level

  assign lowSupIf.cfg      = lowSupervisorCfg;
  assign lowSupIf.autoCtl  = lowSideAutoControl;
  assign lowSupIf.deepLpm  = inDeep;
  assign lowMonIf.cfg      = lowMonitorCfg;
  assign lowMonIf.autoCtl  = lowSideAutoControl;
  assign lowMonIf.deepLpm  = inDeep;
  assign highSupIf.cfg     = highSupervisorCfg;
  assign highSupIf.autoCtl = highSideAutoControl;
  assign highSupIf.deepLpm = inDeep;
  assign highMonIf.cfg     = highMonitorCfg;
  assign highMonIf.autoCtl = highSideAutoControl;
  assign highMonIf.deepLpm = inDeep;

  sssm_unit_mode uLowSup  (.u(lowSupIf));
  sssm_unit_mode uLowMon  (.u(lowMonIf));
  sssm_unit_mode uHighSup (.u(highSupIf));
  sssm_unit_mode uHighMon (.u(highMonIf));

  // =============================================
  // Combinational decode of wake mode and hazard
  logic fastWake;   // Low side gives fast wake
  logic highToOff;  // High side goes normal to off on entry
  always_comb begin
    // Fast unless a low unit is enabled in normal performance
    fastWake = !((lowSupervisorCfg.enable && !lowSupervisorCfg.fullPerf) ||
                 (lowMonitorCfg.enable && !lowMonitorCfg.fullPerf));
    // Normal unit dropped on entry: supervisor not kept or under auto control, monitor under auto control
    highToOff = (highSupervisorCfg.enable && !highSupervisorCfg.fullPerf &&
                 (!highSupervisorCfg.lpmKeep || highSideAutoControl)) ||
                (highMonitorCfg.enable && !highMonitorCfg.fullPerf &&
                 highSideAutoControl);
  end

  // =============================================
  // Settling counters per side
  logic [`SSSM_CNT_W-1:0] lowCnt_reg, lowCnt_next;    // Low side settle count
  logic [`SSSM_CNT_W-1:0] highCnt_reg, highCnt_next;  // High side settle count
  logic                   lowFull, highFull;          // Any full unit on side
  always_comb begin
    lowFull  = (lowSupervisorCfg.enable && lowSupervisorCfg.fullPerf) ||
               (lowMonitorCfg.enable && lowMonitorCfg.fullPerf);
    highFull = (highSupervisorCfg.enable && highSupervisorCfg.fullPerf) ||
               (highMonitorCfg.enable && highMonitorCfg.fullPerf);
    lowCnt_next  = lowCnt_reg;
    highCnt_next = highCnt_reg;
    // A write restarts the delay; otherwise count down to zero
    if (lowSideWrite) begin
      lowCnt_next = settleLen(lowFull);
    end else if (lowCnt_reg != `SSSM_CNT_ZERO) begin
      lowCnt_next = lowCnt_reg - `SSSM_CNT_W'(1);
    end
    if (highSideWrite) begin
      highCnt_next = settleLen(highFull);
    end else if (highCnt_reg != `SSSM_CNT_ZERO) begin
      highCnt_next = highCnt_reg - `SSSM_CNT_W'(1);
    end
  end

  // =============================================
  // Power mode sequencer
  sssm_pkg::sssm_pwr_t    pwr_reg, pwr_next;        // Core power mode
  logic [`SSSM_CNT_W-1:0] wakeCnt_reg, wakeCnt_next; // Wake mask count
  logic [`SSSM_CNT_W-1:0] guard_reg, guard_next;     // Time since entry
  logic                   wakeDone_next;
  logic                   por_next;
  assign inDeep = (pwr_reg == sssm_pkg::SSSM_SLEEP);
  always_comb begin
    pwr_next      = pwr_reg;
    wakeCnt_next  = wakeCnt_reg;
    guard_next    = guard_reg;
    wakeDone_next = 1'b0;
    // Overvoltage while the monitor is alive raises power-on reset
    por_next = overvoltageProtectEnable && overvoltageDetect &&
               (highMonIf.state != `SSSM_ST_OFF);
    case (pwr_reg)
      sssm_pkg::SSSM_ACTIVE: begin
        // Entry by code request or after an interrupt routine
        if (sleepRequest || isrReturnSleep) begin
          pwr_next   = sssm_pkg::SSSM_SLEEP;
          guard_next = `SSSM_CNT_W'(`SSSM_WAKE_GUARD_CYC);
        end
      end
      sssm_pkg::SSSM_SLEEP: begin
        if (guard_reg != `SSSM_CNT_ZERO) begin
          guard_next = guard_reg - `SSSM_CNT_W'(1);
        end
        // Wakes on every interrupt, even inside the first 1 us
        if (wakeInterrupt) begin
          pwr_next     = sssm_pkg::SSSM_WAKING;
          wakeCnt_next = settleLen(fastWake);
        end
      end
      sssm_pkg::SSSM_WAKING: begin
        if (wakeCnt_reg == `SSSM_CNT_ZERO) begin
          pwr_next      = sssm_pkg::SSSM_ACTIVE;
          wakeDone_next = 1'b1;
        end else begin
          wakeCnt_next = wakeCnt_reg - `SSSM_CNT_W'(1);
        end
      end
      default: pwr_next = sssm_pkg::SSSM_ACTIVE;
    endcase
  end

  // =============================================
  // State registers
  // Soft reset also returns a stuck sleep state to active
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_reg     <= sssm_pkg::SSSM_ACTIVE;
      wakeCnt_reg <= `SSSM_CNT_ZERO;
      guard_reg   <= `SSSM_CNT_ZERO;
      lowCnt_reg  <= `SSSM_CNT_ZERO;
      highCnt_reg <= `SSSM_CNT_ZERO;
      wakeDone    <= 1'b0;
      powerOnResetReq <= 1'b0;
    end else if (softReset) begin
      pwr_reg     <= sssm_pkg::SSSM_ACTIVE;
      wakeCnt_reg <= `SSSM_CNT_ZERO;
      guard_reg   <= `SSSM_CNT_ZERO;
      lowCnt_reg  <= `SSSM_CNT_ZERO;
      highCnt_reg <= `SSSM_CNT_ZERO;
      wakeDone    <= 1'b0;
      powerOnResetReq <= 1'b0;
    end else begin
      pwr_reg     <= pwr_next;
      wakeCnt_reg <= wakeCnt_next;
      guard_reg   <= guard_next;
      lowCnt_reg  <= lowCnt_next;
      highCnt_reg <= highCnt_next;
      wakeDone    <= wakeDone_next;
      powerOnResetReq <= por_next;
    end
  end

  // =============================================
  // Registered status outputs
  // Registered so every output comes from a flip-flop; settle flags and deepSleep use next values, the rest lag one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lowSideSettlingFlag  <= 1'b0;
      highSideSettlingFlag <= 1'b0;
      fastWakeMode         <= 1'b0;
      hangHazard           <= 1'b0;
      deepSleep            <= 1'b0;
      lowSupervisorState   <= `SSSM_ST_OFF;
      lowMonitorState      <= `SSSM_ST_OFF;
      highSupervisorState  <= `SSSM_ST_OFF;
      highMonitorState     <= `SSSM_ST_OFF;
    end else begin
      // Software polls these before deep sleep
      // Soft reset masks them so they agree with the cleared counters
      lowSideSettlingFlag  <= !softReset && (lowCnt_next != `SSSM_CNT_ZERO);
      highSideSettlingFlag <= !softReset && (highCnt_next != `SSSM_CNT_ZERO);
      fastWakeMode         <= fastWake;
      hangHazard           <= fastWake && highToOff;
      // Soft reset drops sleep in the same edge as the sequencer
      deepSleep            <= !softReset && (pwr_next == sssm_pkg::SSSM_SLEEP);
      lowSupervisorState   <= lowSupIf.state;
      lowMonitorState      <= lowMonIf.state;
      highSupervisorState  <= highSupIf.state;
      highMonitorState     <= highMonIf.state;
    end
  end
endmodule

/* bench/sssm_top_asserts.sv */
// Port-level checks for the supply supervisor mode block.
// Assumes it is bound onto sssm_top; one clock domain only.
`timescale 1ns/100ps
`include "sssm_defines.svh"
module sssm_top_asserts (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     nrst,
  input wire logic                     softReset,
  // Controls
  input wire sssm_pkg::sssm_unit_cfg_t lowSupervisorCfg,
  input wire sssm_pkg::sssm_unit_cfg_t lowMonitorCfg,
  input wire sssm_pkg::sssm_unit_cfg_t highMonitorCfg,
  input wire logic                     highSideAutoControl,
  input wire logic                     lowSideWrite,
  input wire logic                     overvoltageProtectEnable,
  input wire logic                     overvoltageDetect,
  input wire logic                     sleepRequest,
  input wire logic                     isrReturnSleep,
  input wire logic                     wakeInterrupt,
  // Status
  input wire logic                     deepSleep,
  input wire logic                     fastWakeMode,
  input wire logic                     wakeDone,
  input wire logic                     lowSideSettlingFlag,
  input wire logic [`SSSM_ST_W-1:0]    lowSupervisorState,
  input wire logic [`SSSM_ST_W-1:0]    highMonitorState,
  input wire logic                     powerOnResetReq
);
  // =============================================
  // Clocking; reset silences every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // =============================================
  // Checks
  AST_ENTRY: assert property ($rose(deepSleep) |-> $past(sleepRequest || isrReturnSleep))
    else $error("sleep entered with no request");
  AST_WAKE: assert property (deepSleep && wakeInterrupt && !softReset |=> !deepSleep)
    else $error("interrupt did not wake");
  AST_SOFT: assert property (deepSleep && softReset |=> !deepSleep)
    else $error("soft reset left sleep");
  AST_OVP: assert property ($rose(powerOnResetReq) |-> $past(overvoltageProtectEnable))
    else $error("reset request with protection off");
  AST_FAST: assert property (
    (!lowSupervisorCfg.enable && !lowMonitorCfg.enable) [*2] |-> fastWakeMode)
    else $error("fast wake not chosen");
  AST_SLOW: assert property (
    (lowSupervisorCfg.enable && !lowSupervisorCfg.fullPerf) [*2] |-> !fastWakeMode)
    else $error("slow wake not chosen");
  // Soft reset also drops deepSleep, so only interrupt wakes count
  AST_FAST_LEN: assert property (
    $fell(deepSleep) && fastWakeMode && !$past(softReset) |-> ##[395:405] wakeDone)
    else $error("fast wake length");
  AST_SETTLE: assert property (lowSideWrite && !softReset |=> lowSideSettlingFlag)
    else $error("settling flag not raised");
  AST_AUTO_OFF: assert property (
    (deepSleep && highSideAutoControl && !highMonitorCfg.fullPerf) [*3]
    |-> highMonitorState == `SSSM_ST_OFF) else $error("monitor on asleep");
  AST_DIS_OFF: assert property (
    (!lowSupervisorCfg.enable) [*2] |-> lowSupervisorState == `SSSM_ST_OFF)
    else $error("disabled unit on");
endmodule
bind sssm_top sssm_top_asserts u_chk (.clk_sys, .nrst, .softReset, .lowSupervisorCfg,
  .lowMonitorCfg, .highMonitorCfg, .highSideAutoControl, .lowSideWrite,
  .overvoltageProtectEnable, .overvoltageDetect, .sleepRequest, .isrReturnSleep,
  .wakeInterrupt, .deepSleep, .fastWakeMode, .wakeDone, .lowSideSettlingFlag,
  .lowSupervisorState, .highMonitorState, .powerOnResetReq);

/* bench/sssm_top_test.sv */
// Self-checking bench for the supply supervisor mode block.
// Assumes a 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
`include "sssm_defines.svh"
module sssm_top_test;
  // =============================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0, nrst = 1'b0, softReset = 1'b0, sleepRequest = 1'b0;
  logic isrReturnSleep = 1'b0, wakeInterrupt = 1'b0, lowSideWrite = 1'b0, highSideWrite = 1'b0;
  logic lowSideAutoControl = 1'b0, highSideAutoControl = 1'b0;
  logic overvoltageProtectEnable = 1'b0, overvoltageDetect = 1'b0;
  sssm_pkg::sssm_unit_cfg_t lowSupervisorCfg = 3'h0, lowMonitorCfg = 3'h0;
  sssm_pkg::sssm_unit_cfg_t highSupervisorCfg = 3'h0, highMonitorCfg = 3'h0;
  logic lowSideSettlingFlag, highSideSettlingFlag, fastWakeMode, hangHazard;
  logic deepSleep, wakeDone, powerOnResetReq;
  logic [`SSSM_ST_W-1:0] lowSupervisorState, lowMonitorState, highSupervisorState;
  logic [`SSSM_ST_W-1:0] highMonitorState;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  sssm_top u_dut (
    .clk_sys                  (clk_sys),
    .nrst                     (nrst),
    .softReset                (softReset),
    .lowSupervisorCfg         (lowSupervisorCfg),
    .lowMonitorCfg            (lowMonitorCfg),
    .lowSideAutoControl       (lowSideAutoControl),
    .lowSideWrite             (lowSideWrite),
    .highSupervisorCfg        (highSupervisorCfg),
    .highMonitorCfg           (highMonitorCfg),
    .highSideAutoControl      (highSideAutoControl),
    .highSideWrite            (highSideWrite),
    .overvoltageProtectEnable (overvoltageProtectEnable),
    .overvoltageDetect        (overvoltageDetect),
    .sleepRequest             (sleepRequest),
    .isrReturnSleep           (isrReturnSleep),
    .wakeInterrupt            (wakeInterrupt),
    .lowSideSettlingFlag      (lowSideSettlingFlag),
    .highSideSettlingFlag     (highSideSettlingFlag),
    .fastWakeMode             (fastWakeMode),
    .hangHazard               (hangHazard),
    .deepSleep                (deepSleep),
    .wakeDone                 (wakeDone),
    .lowSupervisorState       (lowSupervisorState),
    .lowMonitorState          (lowMonitorState),
    .highSupervisorState      (highSupervisorState),
    .highMonitorState         (highMonitorState),
    .powerOnResetReq          (powerOnResetReq)
  );
  // Clock and hang guard; the slow settle and slow wake dominate the run
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      error_cnt++;
      summarize;
    end
  end
  // =============================================
  // Shared helpers
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task chkr(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
            input string msg);
    cmp_count++;
    if (!(got >= lo && got <= hi)) begin
      error_cnt++;
      $display("unexpected at %0t: %s %0d", $time, msg, got);
    end
  endtask
  function logic pick(input int s);
    pick = (s == 0) ? wakeDone : (s == 1) ? highSideSettlingFlag : lowSideSettlingFlag;
  endfunction
  // Counts falling edges until the chosen output reaches lvl
  task wsig(input int s, input logic lvl);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(s) !== lvl && n < 35000);
  endtask
  task automatic pulse(ref logic x);
    x = 1'b1;
    @(negedge clk_sys);
    x = 1'b0;
  endtask
  // =============================================
  // Scenarios
  task t_settle;
    lowSupervisorCfg = 3'h5;
    highSupervisorCfg = 3'h5;
    lowSideWrite = 1'b1;
    pulse(highSideWrite);
    lowSideWrite = 1'b0;
    chk(lowSideSettlingFlag, 1'b1, "low flag");
    wsig(1, 1'b0);
    chkr(n, 398, 401, "high settle length");
    @(negedge clk_sys);
    chk(lowSideSettlingFlag, 1'b0, "low flag end");
    $display("test settle done");
  endtask
  task t_fast;
    lowSideAutoControl = 1'b1;
    highSupervisorCfg = 3'h4;
    highMonitorCfg = 3'h6;
    highSideAutoControl = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(fastWakeMode, 1'b1, "fast wake");
    pulse(sleepRequest);
    repeat (3) @(negedge clk_sys);
    chk(deepSleep, 1'b1, "asleep");
    chk(highMonitorState, `SSSM_ST_OFF, "monitor off");
    chk(highSupervisorState, `SSSM_ST_OFF, "supervisor off");
    chk(hangHazard, 1'b1, "hazard");
    pulse(wakeInterrupt);
    wsig(0, 1'b1);
    chkr(n, 398, 404, "fast wake length");
    $display("test fast done");
  endtask
  task t_slow;
    lowSupervisorCfg = 3'h6;
    lowMonitorCfg = 3'h6;
    lowSideAutoControl = 1'b0;
    highSideAutoControl = 1'b0;
    pulse(lowSideWrite);
    // Normal units only: the full 150 us settle is waited out before sleep
    wsig(2, 1'b0);
    chkr(n, 29998, 30001, "low settle length");
    repeat (2) @(negedge clk_sys);
    chk(fastWakeMode, 1'b0, "slow wake");
    pulse(isrReturnSleep);
    repeat (3) @(negedge clk_sys);
    chk(deepSleep, 1'b1, "asleep");
    chk(lowSupervisorState, `SSSM_ST_NORM, "kept normal");
    chk(lowMonitorState, `SSSM_ST_NORM, "monitor kept normal");
    chk(highMonitorState, `SSSM_ST_NORM, "manual on");
    chk(hangHazard, 1'b0, "no hazard");
    pulse(wakeInterrupt);
    wsig(0, 1'b1);
    chkr(n, 29998, 30004, "slow wake length");
    $display("test slow done");
  endtask
  task t_soft;
    overvoltageProtectEnable = 1'b1;
    overvoltageDetect = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(powerOnResetReq, 1'b1, "overvoltage reset");
    overvoltageProtectEnable = 1'b0;
    pulse(sleepRequest);
    repeat (2) @(negedge clk_sys);
    chk(powerOnResetReq, 1'b0, "protection off");
    chk(deepSleep, 1'b1, "asleep before soft reset");
    pulse(softReset);
    chk(deepSleep, 1'b0, "soft reset wakes");
    $display("test soft done");
  endtask
  // =============================================
  // Verdict
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    t_settle;
    t_fast;
    t_slow;
    t_soft;
    summarize;
  end
endmodule
